// ---- hdl/srn_node.sv ----
/*
  Serial ring node: 38-state message sequencer, wired data line,
  chain arbitration, status flags and byte register port.
  Assumes the serial clock is slow against clk and all pins are asynchronous.
*/
`timescale 1ns/10ps
`include "srn_regs.svh"

module srn_node import srn_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire srn_req_t bus_req,
  output logic [7:0] rd_data,
  // ring pins
  input wire logic serial_clock_line,
  input wire logic sdl_in,
  output logic sdl_out,
  output logic sdl_oe,
  input wire logic chain_input,
  output logic chain_output,
  // processor interrupt
  output logic node_interrupt
);
  function automatic srn_phase_t phase_of(input logic [5:0] s);
    if (s == `SRN_ST_IDLE) return SRN_PH_IDLE;
    if (s == `SRN_ST_ARB) return SRN_PH_ARB;
    if (s == `SRN_ST_LOAD) return SRN_PH_LOAD;
    if (s <= `SRN_ST_XFER_END) return SRN_PH_XFER;
    if (s == `SRN_ST_PREP) return SRN_PH_PREP;
    if (s == `SRN_ST_ACK) return SRN_PH_ACK;
    return SRN_PH_DONE;
  endfunction

  logic [2:0] pins_s;
  logic sclk_s, sdl_s, chain_s;
  logic sclk_q_ff, nxt_sclk_q;
  logic [5:0] state_ff, nxt_state;
  logic rise, fall;
  srn_phase_t phase;
  srn_flags_t flags_ff, nxt_flags;
  logic load_done_ff, nxt_load_done;
  logic sample_ff, nxt_sample;
  logic [2:0] node_ff, nxt_node;
  logic ring_en_ff, nxt_ring_en;
  logic chain_ff, nxt_chain;
  logic sdl_out_ff, nxt_sdl_out, sdl_oe_ff, nxt_sdl_oe;
  logic irq_ff, nxt_irq;
  logic [7:0] rd_ff, nxt_rd;
  logic [31:0] msg;
  logic match, hearing, shift_en, msg_wr, wr_msg0, rd_msg3;

  srn_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({serial_clock_line, sdl_in, chain_input}),
    .sync_out(pins_s)
  );

  assign {sclk_s, sdl_s, chain_s} = pins_s;
  assign rise = sclk_s & ~sclk_q_ff;
  assign fall = ~sclk_s & sclk_q_ff;
  assign phase = phase_of(state_ff);
  assign match = (msg[31:29] == node_ff);
  assign hearing = ~flags_ff.deaf;
  assign shift_en = rise & (phase == SRN_PH_XFER) & hearing;
  assign msg_wr = bus_req.wr & (bus_req.addr >= `SRN_ADDR_MSG0)
    & (bus_req.addr <= `SRN_ADDR_MSG3);
  assign wr_msg0 = bus_req.wr & (bus_req.addr == `SRN_ADDR_MSG0);
  assign rd_msg3 = bus_req.rd & (bus_req.addr == `SRN_ADDR_MSG3);

  srn_shifter u_shift (
    .clk(clk),
    .rst(rst),
    .wr_en(msg_wr),
    .wr_idx(2'(bus_req.addr - `SRN_ADDR_MSG0)),
    .wr_data(bus_req.wdata),
    .shift_en(shift_en),
    .shift_in(sample_ff),
    .msg(msg)
  );

  // sequencer: counts rising serial clock edges; a stopped clock is the wait
  always_comb begin
    nxt_sclk_q = sclk_s;
    nxt_state = state_ff;
    nxt_sample = sample_ff;
    if (rise) begin
      nxt_state = (state_ff == `SRN_ST_LAST) ? `SRN_ST_IDLE
        : 6'(state_ff + 6'h01);
    end
    if (fall && phase == SRN_PH_XFER && hearing) begin
      nxt_sample = sdl_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
      state_ff <= `SRN_ST_IDLE;
      sample_ff <= 1'b0;
    end else begin
      sclk_q_ff <= nxt_sclk_q;
      state_ff <= nxt_state;
      sample_ff <= nxt_sample;
    end
  end

  // flags and software-owned control
  always_comb begin
    nxt_flags = flags_ff;
    nxt_load_done = load_done_ff;
    nxt_node = node_ff;
    nxt_ring_en = ring_en_ff;
    nxt_chain = chain_ff;
    // clears first so that hardware sets win in the same cycle
    if (rd_msg3) begin
      nxt_flags.read_pend = 1'b0;
    end
    if (wr_msg0) begin
      nxt_flags.write_pend = 1'b0;
      if (flags_ff.master && phase == SRN_PH_LOAD) begin
        nxt_load_done = 1'b1;
      end
    end
    if (bus_req.wr && bus_req.addr == `SRN_ADDR_STATUS) begin
      if (bus_req.wdata[`SRN_B_WPEND]) nxt_flags.write_pend = 1'b1;
      if (bus_req.wdata[`SRN_B_PREV]) nxt_flags.prev_master = 1'b1;
    end
    if (bus_req.wr && bus_req.addr == `SRN_ADDR_NODE) begin
      nxt_node = bus_req.wdata[2:0];
    end
    if (bus_req.wr && bus_req.addr == `SRN_ADDR_CTRL) begin
      nxt_ring_en = bus_req.wdata[`SRN_B_RING_EN];
    end
    if (phase == SRN_PH_ARB) begin
      nxt_chain = flags_ff.prev_master | (chain_s & ~flags_ff.write_pend);
    end
    if (rise) begin
      case (state_ff)
        `SRN_ST_IDLE: begin
          nxt_flags.prev_master = flags_ff.master;
          nxt_flags.master = 1'b0;
        end
        `SRN_ST_ARB: begin
          nxt_flags.master = flags_ff.write_pend & chain_s;
        end
        `SRN_ST_LOAD: begin
          nxt_flags.deaf = flags_ff.read_pend;
          nxt_load_done = 1'b0;
        end
        `SRN_ST_ACK: begin
          if (flags_ff.master) begin
            nxt_flags.nack = sdl_s;
          end
          if (match && hearing) begin
            nxt_flags.read_pend = 1'b1;
          end
        end
        `SRN_ST_LAST: begin
          nxt_flags.deaf = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= `SRN_FLAGS_RST;
      load_done_ff <= 1'b0;
      node_ff <= `SRN_NODE_RST;
      ring_en_ff <= 1'b0;
      chain_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      load_done_ff <= nxt_load_done;
      node_ff <= nxt_node;
      ring_en_ff <= nxt_ring_en;
      chain_ff <= nxt_chain;
    end
  end

  // data line drive; released means enable low
  always_comb begin
    nxt_sdl_oe = 1'b0;
    nxt_sdl_out = 1'b1;
    nxt_irq = ring_en_ff & (flags_ff.master | flags_ff.nack | flags_ff.read_pend);
    case (phase)
      SRN_PH_LOAD: begin
        if (flags_ff.master && load_done_ff) begin
          nxt_sdl_oe = 1'b1;
          nxt_sdl_out = 1'b0;
        end
      end
      SRN_PH_XFER: begin
        if (flags_ff.master) begin
          nxt_sdl_oe = 1'b1;
          nxt_sdl_out = msg[31];
        end
      end
      SRN_PH_PREP, SRN_PH_DONE: begin
        if (flags_ff.master) begin
          nxt_sdl_oe = 1'b1;
          nxt_sdl_out = 1'b1;
        end
      end
      SRN_PH_ACK: begin
        if (match && hearing) begin
          nxt_sdl_oe = 1'b1;
          nxt_sdl_out = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdl_oe_ff <= 1'b0;
      sdl_out_ff <= 1'b1;
      irq_ff <= 1'b0;
    end else begin
      sdl_oe_ff <= nxt_sdl_oe;
      sdl_out_ff <= nxt_sdl_out;
      irq_ff <= nxt_irq;
    end
  end

  // register readback, valid only in the cycle after the strobe
  always_comb begin
    nxt_rd = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `SRN_ADDR_STATE: nxt_rd = 8'(8'h01 << phase);
        `SRN_ADDR_MSG0: nxt_rd = msg[7:0];
        `SRN_ADDR_MSG1: nxt_rd = msg[15:8];
        `SRN_ADDR_MSG2: nxt_rd = msg[23:16];
        `SRN_ADDR_MSG3: nxt_rd = msg[31:24];
        `SRN_ADDR_STATUS: nxt_rd = {2'b00, flags_ff};
        `SRN_ADDR_NODE: nxt_rd = {5'h00, node_ff};
        `SRN_ADDR_CTRL: nxt_rd = 8'({ring_en_ff, 2'b00});
        default: nxt_rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ff <= 8'h00;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  assign rd_data = rd_ff;
  assign sdl_out = sdl_out_ff;
  assign sdl_oe = sdl_oe_ff;
  assign chain_output = chain_ff;
  assign node_interrupt = irq_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_deaf_on_entry: assert property (rise && state_ff == `SRN_ST_LOAD
    |=> flags_ff.deaf == $past(flags_ff.read_pend)) else $error("deaf not taken at state 3");
  a_master_data_drive: assert property (flags_ff.master && phase == SRN_PH_XFER
    |=> sdl_oe && sdl_out == $past(msg[31])) else $error("master not driving data");
  a_shift_on_rise: assert property (shift_en
    |=> msg == {$past(msg[30:0]), $past(sample_ff)}) else $error("message did not shift");
  a_sample_on_fall: assert property (fall && phase == SRN_PH_XFER && hearing
    |=> sample_ff == $past(sdl_s)) else $error("falling edge sample lost");
  a_begin_marker: assert property (flags_ff.master && load_done_ff
    && phase == SRN_PH_LOAD |=> sdl_oe && !sdl_out) else $error("begin marker missing");
  a_prep_high: assert property (flags_ff.master && phase == SRN_PH_PREP
    |=> sdl_oe && sdl_out) else $error("line not high before acknowledge");
  a_ack_pull: assert property (phase == SRN_PH_ACK && match && hearing
    |=> sdl_oe && !sdl_out) else $error("acknowledge not pulled");
  a_nack_capture: assert property (rise && state_ff == `SRN_ST_ACK && flags_ff.master
    |=> flags_ff.nack == $past(sdl_s)) else $error("nack not captured");
  a_read_pend_set: assert property (rise && state_ff == `SRN_ST_ACK && match && hearing
    |=> flags_ff.read_pend) else $error("read pending not set");
  a_state_wrap: assert property (rise && state_ff == `SRN_ST_LAST
    |=> state_ff == `SRN_ST_IDLE ##1 !flags_ff.deaf) else $error("counter failed to wrap");
  a_irq_follows: assert property (##1 node_interrupt == $past(ring_en_ff
    & (flags_ff.master | flags_ff.nack | flags_ff.read_pend))) else $error("interrupt mismatch");
  a_read_clear: assert property (rd_msg3 && !(rise && state_ff == `SRN_ST_ACK)
    |=> !flags_ff.read_pend) else $error("read pending not cleared");

  c_nack_seen: cover property (rise && state_ff == `SRN_ST_ACK && flags_ff.master && sdl_s);
  c_message_in: cover property (rise && state_ff == `SRN_ST_ACK && match && hearing);
  c_deaf_node: cover property (rise && state_ff == `SRN_ST_LOAD && flags_ff.read_pend);
endmodule

// ---- hdl/srn_pkg.sv ----
/*
  Types of the serial ring node: phases, flag set, register request.
  Assumes srn_regs.svh holds the numeric constants.
*/
package srn_pkg;
  typedef enum logic [2:0] {
    SRN_PH_IDLE = 3'b000,
    SRN_PH_ARB = 3'b001,
    SRN_PH_LOAD = 3'b010,
    SRN_PH_XFER = 3'b011,
    SRN_PH_PREP = 3'b100,
    SRN_PH_ACK = 3'b101,
    SRN_PH_DONE = 3'b110
  } srn_phase_t;

  // bit order equals the status register layout
  typedef struct packed {
    logic deaf;
    logic read_pend;
    logic nack;
    logic prev_master;
    logic master;
    logic write_pend;
  } srn_flags_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } srn_req_t;
endpackage

// ---- hdl/srn_regs.svh ----
/*
  Register offsets, field positions, reset values and state counts of the
  serial ring node. Assumes a 5-bit byte-wide register port.
*/
`ifndef SRN_REGS_SVH
`define SRN_REGS_SVH

`define SRN_ADDR_STATE 5'h14
`define SRN_ADDR_MSG0 5'h15
`define SRN_ADDR_MSG1 5'h16
`define SRN_ADDR_MSG2 5'h17
`define SRN_ADDR_MSG3 5'h18
`define SRN_ADDR_STATUS 5'h19
`define SRN_ADDR_NODE 5'h1a
`define SRN_ADDR_CTRL 5'h1b

`define SRN_B_WPEND 0
`define SRN_B_PREV 2
`define SRN_B_RING_EN 2

`define SRN_FLAGS_RST 6'h00
`define SRN_NODE_RST 3'h0
`define SRN_MSG_RST 32'h0000_0000

`define SRN_ST_IDLE 6'h00
`define SRN_ST_ARB 6'h01
`define SRN_ST_LOAD 6'h02
`define SRN_ST_XFER 6'h03
`define SRN_ST_XFER_END 6'h22
`define SRN_ST_PREP 6'h23
`define SRN_ST_ACK 6'h24
`define SRN_ST_LAST 6'h25

`endif

// ---- hdl/srn_shifter.sv ----
/*
  32-bit message register: byte writes from software, one-bit left shift.
  Assumes shift and write never coincide; shift wins if they do.
*/
`timescale 1ns/10ps
`include "srn_regs.svh"
module srn_shifter import srn_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software byte write
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // serial shift
  input wire logic shift_en,
  input wire logic shift_in,
  output logic [31:0] msg
);
  logic [31:0] msg_ff, nxt_msg;

  always_comb begin
    nxt_msg = msg_ff;
    if (shift_en) begin
      nxt_msg = {msg_ff[30:0], shift_in};
    end else if (wr_en) begin
      nxt_msg[wr_idx*8 +: 8] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_ff <= `SRN_MSG_RST;
    end else begin
      msg_ff <= nxt_msg;
    end
  end

  assign msg = msg_ff;
endmodule

// ---- hdl/srn_sync.sv ----
/*
  Two-stage synchroniser for pin inputs.
  Assumes inputs are asynchronous to clk; only stage two is read outside.
*/
`timescale 1ns/10ps
module srn_sync #(parameter int W = 3) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and result
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_ff, stage2_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule

// ---- verif/srn_ring_model.sv ----
/*
  Far side of the ring for one serial ring node: the serial clock source
  and one other node, acting as remote master or as remote receiver.
  Assumes the data line has a pull-up and is resolved by the bench.
*/
`timescale 1ns/10ps
module srn_ring_model (
  // link pins
  output logic serial_clock_line,
  output logic pull_low,
  input wire logic line,
  input wire logic chain_seen
);
  int st;
  bit go;
  logic cho;
  logic lvl [0:37];

  initial begin
    serial_clock_line = 1'b0;
    pull_low = 1'b0;
    st = 0;
    go = 1'b0;
    cho = 1'b0;
  end

  // one message, 64 ns per state; the clock stands still outside frames
  task automatic frame(input bit dm, input logic [31:0] w, input bit ack);
    int s;
    for (s = 1; s <= 38; s++) begin
      serial_clock_line = 1'b1;
      st = s % 38;
      #24;
      // drive changes after the rise; only ever pull low or release
      if (dm) begin
        pull_low = (st == 36) && ack;
      end else begin
        pull_low = (st == 2) || (st >= 3 && st <= 34 && !w[34 - st]);
      end
      #8;
      serial_clock_line = 1'b0;
      // a device master stalls the clock in state 2 until its load
      if (dm && st == 2) begin
        wait (go);
        #40;
      end
      #31;
      // latest settled point of the bit cell
      lvl[st] = line;
      if (st == 1) begin
        cho = chain_seen;
      end
      #1;
    end
  endtask
endmodule

// ---- verif/test_token_ring_serial_message_phase.sv ----
/*
  Self-checking bench of the serial ring node: register port, device as
  master, as receiver, deaf and unaddressed. Assumes srn_ring_model.
*/
`timescale 1ns/10ps
`include "srn_regs.svh"
module test_token_ring_serial_message_phase import srn_pkg::*; ;
  logic clk;
  logic rst;
  srn_req_t req;
  logic [7:0] rd_data;
  logic sclk;
  logic sdl_out;
  logic sdl_oe;
  logic chain_input;
  logic chain_output;
  logic node_interrupt;
  logic pull;
  logic line;
  logic rd_q;
  logic [7:0] exp_q [$];
  int n_errors;
  int num_checks;
  int cycles;
  logic [31:0] seed;
  logic [31:0] w2;
  logic [2:0] na;
  int k;

  // wired line with pull-up
  assign line = pull ? 1'b0 : (sdl_oe ? sdl_out : 1'b1);

  srn_node dut (
    .clk(clk),
    .rst(rst),
    .bus_req(req),
    .rd_data(rd_data),
    .serial_clock_line(sclk),
    .sdl_in(line),
    .sdl_out(sdl_out),
    .sdl_oe(sdl_oe),
    .chain_input(chain_input),
    .chain_output(chain_output),
    .node_interrupt(node_interrupt)
  );

  srn_ring_model m (
    .serial_clock_line(sclk),
    .pull_low(pull),
    .line(line),
    .chain_seen(chain_output)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= {a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back(e);
    @(posedge clk);
    req <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= req.rd;
    if (rd_q) begin
      check(rd_data, exp_q.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // five frames take under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  task automatic frame(input bit dm, input logic [31:0] w, input bit ack, input logic [7:0] st2,
                       input logic [7:0] s35, input logic [7:0] sfin, input logic cho);
    logic [7:0] oh [5] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h01};
    int sts [5] = '{3, 35, 36, 37, 0};
    int i;
    // serial edges land on falling clk edges, never on rising ones
    @(negedge clk);
    m.go = 1'b0;
    fork
      m.frame(dm, w, dm & ack);
      begin
        if (dm) begin
          wait (m.st == 2);
          repeat (3) @(posedge clk);
          rd(`SRN_ADDR_STATE, 8'h04);
          rd(`SRN_ADDR_STATUS, st2);
          for (i = 3; i >= 0; i--) wr(5'(`SRN_ADDR_MSG0 + i), w[8*i +: 8]);
          @(negedge clk);
          m.go = 1'b1;
        end
        for (i = 0; i < 5; i++) begin
          wait (m.st == sts[i]);
          repeat (3) @(posedge clk);
          rd(`SRN_ADDR_STATE, oh[i]);
          if (i == 1) rd(`SRN_ADDR_STATUS, s35);
        end
      end
    join
    if (dm) begin
      check(m.lvl[2], 1'b0);
      for (i = 3; i < 35; i++) check(m.lvl[i], w[34 - i]);
    end
    check(m.lvl[35], 1'b1);
    check(m.lvl[36], !ack);
    check(m.lvl[37], 1'b1);
    check(m.cho, cho);
    rd(`SRN_ADDR_STATUS, sfin);
    @(negedge clk);
    check(node_interrupt, sfin[1] | sfin[3] | sfin[4]);
    check(sdl_oe, 1'b0);
    $display("frame test done, device master %0d", dm);
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    chain_input = 1'b0;
    rd_q = 1'b0;
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    seed = 32'h9f8f_4f16;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    seed = lfsr(seed);
    na = seed[2:0];
    rd(`SRN_ADDR_STATE, 8'h01);
    rd(`SRN_ADDR_STATUS, 8'h00);
    rd(`SRN_ADDR_MSG3, 8'h00);
    rd(5'h00, 8'h00);
    wr(`SRN_ADDR_NODE, {5'h00, na});
    wr(`SRN_ADDR_CTRL, 8'h04);
    rd(`SRN_ADDR_NODE, {5'h00, na});
    rd(`SRN_ADDR_CTRL, 8'h04);
    // previous-master flag is software settable, arbitration overwrites it
    wr(`SRN_ADDR_STATUS, 8'h04);
    rd(`SRN_ADDR_STATUS, 8'h04);
    @(negedge clk);
    check(node_interrupt, 1'b0);
    $display("register test done");
    // device as master: no acknowledge, then acknowledged
    wr(`SRN_ADDR_STATUS, 8'h01);
    chain_input <= 1'b1;
    seed = lfsr(seed);
    frame(1, {~na, seed[28:0]}, 0, 8'h03, 8'h02, 8'h0a, 1'b0);
    rd(`SRN_ADDR_MSG3, {~na, seed[28:24]});
    wr(`SRN_ADDR_STATUS, 8'h01);
    seed = lfsr(seed);
    frame(1, {~na, seed[28:0]}, 1, 8'h0f, 8'h0e, 8'h06, 1'b1);
    // device as receiver, then deaf while the first message is unread
    chain_input <= 1'b0;
    seed = lfsr(seed);
    w2 = {na, seed[28:0]};
    frame(0, w2, 1, 8'h00, 8'h04, 8'h14, 1'b1);
    seed = lfsr(seed);
    frame(0, {na, seed[28:0]}, 0, 8'h00, 8'h30, 8'h10, 1'b0);
    for (k = 0; k < 4; k++) rd(5'(`SRN_ADDR_MSG0 + k), w2[8*k +: 8]);
    rd(`SRN_ADDR_STATUS, 8'h00);
    @(negedge clk);
    check(node_interrupt, 1'b0);
    // unaddressed message is still shifted in
    chain_input <= 1'b1;
    seed = lfsr(seed);
    frame(0, {na + 3'd1, seed[28:0]}, 0, 8'h00, 8'h00, 8'h00, 1'b1);
    rd(`SRN_ADDR_MSG3, {na + 3'd1, seed[28:24]});
    repeat (4) @(posedge clk);
    results();
  end
endmodule
